// File: core/rio_pkg.sv
package rio_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] RIO_OFF_BUS_ERR = 8'h00;
  localparam logic [7:0] RIO_OFF_MASTER_ERR = 8'h04;
  localparam logic [7:0] RIO_OFF_FAIL_INFO = 8'h08;
  localparam logic [7:0] RIO_OFF_REFRESH = 8'h0c;
  localparam logic [7:0] RIO_OFF_ALLOC_REQ = 8'h10;
  localparam logic [7:0] RIO_OFF_ALLOC_RES = 8'h14;
  localparam logic [7:0] RIO_OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] RIO_OFF_IRQ_CLEAR = 8'h1c;
  localparam logic [7:0] RIO_OFF_IRQ_ENABLE = 8'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RIO_BIT_BUS_ERR = 5;
  localparam int RIO_BIT_MASTER0 = 0;
  localparam int RIO_BIT_MASTER1 = 1;
  localparam int RIO_BIT_REFRESH = 0;
  localparam int RIO_BIT_FLAG_CLR = 1;
  localparam int RIO_REQ_KIND_LSB = 0;
  localparam int RIO_REQ_UNIT_LSB = 8;
  localparam int RIO_REQ_IDX_LSB = 16;
  localparam int RIO_RES_VALID_BIT = 16;
  localparam int RIO_IRQ_BUS = 0;
  localparam int RIO_IRQ_FAIL = 1;
  localparam int RIO_IRQ_W = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] RIO_REQ_RESET = 32'h0000_0000;
  localparam logic [15:0] RIO_INFO_RESET = 16'h0000;
  localparam logic [RIO_IRQ_W-1:0] RIO_IRQ_RESET = 2'h0;

  // ****************************************
  // Word allocation
  // ****************************************
  localparam logic [13:0] RIO_RACK_BASE = 14'hbb8;
  localparam logic [13:0] RIO_RACK_LAST = 14'hbe9;
  localparam logic [13:0] RIO_TERM_BASE = 14'hc1c;
  localparam logic [13:0] RIO_TERM_LAST = 14'hc3b;
  localparam logic [4:0] RIO_RACK_WORDS = 5'h0a;
  localparam logic [4:0] RIO_LARGE_WORDS = 5'h14;
  localparam logic [4:0] RIO_OPTIC_WORDS = 5'h02;
  localparam logic [4:0] RIO_RACK_UNIT_MAX = 5'h04;
  localparam logic [4:0] RIO_LARGE_UNIT_MAX = 5'h03;
  localparam logic [4:0] RIO_TERM_UNIT_MAX = 5'h1f;

  localparam logic [1:0] RIO_KIND_RACK = 2'h0;
  localparam logic [1:0] RIO_KIND_LARGE = 2'h1;
  localparam logic [1:0] RIO_KIND_TERM = 2'h2;
  localparam logic [1:0] RIO_KIND_OPTIC = 2'h3;

  // ****************************************
  // Failure information codes
  // ****************************************
  localparam logic [7:0] RIO_MASTER0_CODE = 8'hb0;
  localparam logic [7:0] RIO_MASTER1_CODE = 8'hb1;

endpackage

// File: core/rio_alloc.sv
module rio_alloc
  import rio_pkg::*;
(
  input wire logic [1:0] kind_i,
  input wire logic [4:0] unit_i,
  input wire logic [4:0] index_i,
  output logic [13:0] addr_o,
  output logic valid_o
);

  logic [13:0] rack_off;

  // Unit times ten; master count plays no part in placement
  assign rack_off = {6'h00, unit_i, 3'h0} + {8'h00, unit_i, 1'h0};

  always_comb begin
    addr_o = RIO_RACK_BASE + rack_off + {9'h000, index_i};
    valid_o = 1'b0;
    case (kind_i)
      RIO_KIND_RACK: begin
        valid_o = (unit_i <= RIO_RACK_UNIT_MAX) && (index_i < RIO_RACK_WORDS);
      end
      RIO_KIND_LARGE: begin
        valid_o = (unit_i <= RIO_LARGE_UNIT_MAX) && (index_i < RIO_LARGE_WORDS);
      end
      RIO_KIND_TERM: begin
        addr_o = RIO_TERM_BASE + {9'h000, unit_i};
        valid_o = (unit_i <= RIO_TERM_UNIT_MAX) && (index_i == 5'h00);
      end
      RIO_KIND_OPTIC: begin
        addr_o = RIO_TERM_BASE + {9'h000, unit_i} + {9'h000, index_i};
        valid_o = index_i < RIO_OPTIC_WORDS;
      end
      default: begin
        valid_o = 1'b0;
      end
    endcase
    // Nothing outside the two reserved windows is ever handed out
    if (addr_o < RIO_RACK_BASE || addr_o > RIO_TERM_LAST ||
        (addr_o > RIO_RACK_LAST && addr_o < RIO_TERM_BASE)) begin
      valid_o = 1'b0;
    end
  end

endmodule

// File: core/rio_err.sv
module rio_err
  import rio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bus_err_i,
  input wire logic err_master_i,
  input wire logic fail_i,
  input wire logic fail_optic_i,
  input wire logic [4:0] fail_unit_i,
  input wire logic fail_high_i,
  input wire logic fail_master_i,
  input wire logic refresh_i,
  input wire logic flag_clr_i,
  output logic bus_err_o,
  output logic [1:0] master_err_o,
  output logic [15:0] info_o,
  output logic held_o
);

  logic bus_err_q, bus_err_d;
  logic [1:0] master_q, master_d;
  logic [15:0] info_q, info_d, shadow_q, shadow_d, fail_word;
  logic held_q, held_d, shadow_ok_q, shadow_ok_d;

  always_comb begin
    fail_word = RIO_INFO_RESET;
    if (fail_optic_i) begin
      fail_word[15:8] = {3'h0, fail_unit_i};
      fail_word[4] = fail_high_i;
    end else begin
      fail_word[15:8] = fail_master_i ? RIO_MASTER1_CODE : RIO_MASTER0_CODE;
      fail_word[6:4] = fail_unit_i[2:0];
    end
  end

  always_comb begin
    // A new error wins over a clear in the same cycle
    bus_err_d = (bus_err_q & ~flag_clr_i) | bus_err_i;
    master_d = master_q & {2{~flag_clr_i}};
    if (bus_err_i) begin
      master_d[err_master_i] = 1'b1;
    end
    shadow_d = fail_i ? fail_word : shadow_q;
    shadow_ok_d = shadow_ok_q | fail_i;
    info_d = info_q;
    held_d = held_q;
    if (fail_i && !held_q) begin
      info_d = fail_word;
      held_d = 1'b1;
    end else if (refresh_i) begin
      // Refresh shows the newest failure seen since the last refresh, the one that froze the word included
      info_d = shadow_ok_d ? shadow_d : RIO_INFO_RESET;
      held_d = shadow_ok_d;
      shadow_ok_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_err_q <= 1'b0;
      master_q <= 2'h0;
      info_q <= RIO_INFO_RESET;
      shadow_q <= RIO_INFO_RESET;
      shadow_ok_q <= 1'b0;
      held_q <= 1'b0;
    end else begin
      bus_err_q <= bus_err_d;
      master_q <= master_d;
      info_q <= info_d;
      shadow_q <= shadow_d;
      shadow_ok_q <= shadow_ok_d;
      held_q <= held_d;
    end
  end

  assign bus_err_o = bus_err_q;
  assign master_err_o = master_q;
  assign info_o = info_q;
  assign held_o = held_q;

endmodule

// File: core/rio_top.sv
// How it works
// - Racks get ten words from 3000 by unit
// - One word per slot, leftmost slot first
// - Placement ignores how many masters exist
// - Large racks take twenty words, units 0-3
// - Other slaves at 3100 plus unit; optical two
// - Transmission error sets the bus error flag
// - Bus error sets the involved master's flag
// - Failing rack unit goes into three-bit field
// - Optical failure stores unit number 00-1F
// - Refresh bit reloads the failing-slave word
// - No general data or unit words used
module rio_top
  import rio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bus_err_i,
  input wire logic err_master_i,
  input wire logic fail_i,
  input wire logic fail_optic_i,
  input wire logic [4:0] fail_unit_i,
  input wire logic fail_high_i,
  input wire logic fail_master_i,
  output logic bus_err_o,
  output logic irq_o
);

  // ****************************************
  // Helpers
  // ****************************************
  // Unselected byte lanes leave their bits untouched
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = adr == off;
  endfunction

  // ****************************************
  // Wishbone slave
  // ****************************************
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic wb_req;
  logic wr_now;
  logic [31:0] wmask;
  logic [31:0] wdata;

  // Classic cycle: cyc and stb qualify the access together
  assign wb_req = wb_cyc_i && wb_stb_i;
  // Writes land on the edge where the master samples ack
  assign wr_now = wb_req && wb_we_i && ack_q;
  assign wmask = lane_mask(wb_sel_i);
  assign wdata = wb_dat_i & wmask;

  // ****************************************
  // Write strobes
  // ****************************************
  logic wr_req;
  logic wr_refresh;
  logic wr_irq_clr;
  logic wr_irq_en;

  // One decode per writable register keeps each offset in one place
  assign wr_req = wr_now && hit(wb_adr_i, RIO_OFF_ALLOC_REQ);
  assign wr_refresh = wr_now && hit(wb_adr_i, RIO_OFF_REFRESH);
  assign wr_irq_clr = wr_now && hit(wb_adr_i, RIO_OFF_IRQ_CLEAR);
  assign wr_irq_en = wr_now && hit(wb_adr_i, RIO_OFF_IRQ_ENABLE);

  // ****************************************
  // Allocation lookup
  // ****************************************
  logic [31:0] req_q, req_d;
  logic [1:0] req_kind;
  logic [4:0] req_unit;
  logic [4:0] req_index;
  logic [13:0] alloc_addr;
  logic alloc_ok;
  logic [31:0] res_q, res_d;

  // The lookup runs on the stored request, so its registered result
  // trails the landing write by one edge and then stays put
  assign req_kind = req_q[RIO_REQ_KIND_LSB +: 2];
  assign req_unit = req_q[RIO_REQ_UNIT_LSB +: 5];
  assign req_index = req_q[RIO_REQ_IDX_LSB +: 5];

  rio_alloc u_alloc (
    .kind_i(req_kind),
    .unit_i(req_unit),
    .index_i(req_index),
    .addr_o(alloc_addr),
    .valid_o(alloc_ok)
  );

  always_comb begin
    req_d = req_q;
    if (wr_req) begin
      req_d = (req_q & ~wmask) | wdata;
    end
    // Only the used request fields are kept
    req_d[31:21] = 11'h000;
    req_d[15:13] = 3'h0;
    req_d[7:2] = 6'h00;
    res_d = 32'h0000_0000;
    // The valid bit lets software tell a refused request from a real word
    res_d[13:0] = alloc_addr;
    res_d[RIO_RES_VALID_BIT] = alloc_ok;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= RIO_REQ_RESET;
      res_q <= 32'h0000_0000;
    end else begin
      req_q <= req_d;
      res_q <= res_d;
    end
  end

  // ****************************************
  // Error capture
  // ****************************************
  logic refresh_pulse;
  logic flag_clr_pulse;
  logic err_flag;
  logic [1:0] master_flags;
  logic [15:0] fail_info;
  logic fail_held;

  // Refresh and flag clear share one write-only register, one bit each
  assign refresh_pulse = wr_refresh && wdata[RIO_BIT_REFRESH];
  assign flag_clr_pulse = wr_refresh && wdata[RIO_BIT_FLAG_CLR];

  rio_err u_err (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus_err_i(bus_err_i),
    .err_master_i(err_master_i),
    .fail_i(fail_i),
    .fail_optic_i(fail_optic_i),
    .fail_unit_i(fail_unit_i),
    .fail_high_i(fail_high_i),
    .fail_master_i(fail_master_i),
    .refresh_i(refresh_pulse),
    .flag_clr_i(flag_clr_pulse),
    .bus_err_o(err_flag),
    .master_err_o(master_flags),
    .info_o(fail_info),
    .held_o(fail_held)
  );

  // ****************************************
  // Interrupts
  // ****************************************
  wire logic [RIO_IRQ_W-1:0] irq_stat_q;
  wire logic [RIO_IRQ_W-1:0] irq_stat_d;
  wire logic [RIO_IRQ_W-1:0] irq_en_q;
  wire logic [RIO_IRQ_W-1:0] irq_en_d;
  logic [RIO_IRQ_W-1:0] irq_evt;
  logic irq_q, irq_d;
  logic bus_err_q, bus_err_d;

  always_comb begin
    irq_evt = '0;
    irq_evt[RIO_IRQ_BUS] = bus_err_i;
    irq_evt[RIO_IRQ_FAIL] = fail_i;
  end

  // Every status bit is a sticky cell of its own beside its enable
  for (genvar b = 0; b < RIO_IRQ_W; b++) begin : g_irq
    logic stat_q, stat_d;
    logic en_q, en_d;

    always_comb begin
      // An event in the clearing cycle survives the clear
      stat_d = (stat_q & ~(wr_irq_clr & wdata[b])) | irq_evt[b];
      en_d = en_q;
      // Enable bits obey the byte lanes like any read-write field
      if (wr_irq_en && wmask[b]) begin
        en_d = wdata[b];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        stat_q <= RIO_IRQ_RESET[b];
        en_q <= RIO_IRQ_RESET[b];
      end else begin
        stat_q <= stat_d;
        en_q <= en_d;
      end
    end

    assign irq_stat_q[b] = stat_q;
    assign irq_stat_d[b] = stat_d;
    assign irq_en_q[b] = en_q;
    assign irq_en_d[b] = en_d;
  end

  // The level output is registered from the next state, so it rises
  // on the same edge as the status bit that causes it
  always_comb begin
    irq_d = |(irq_stat_d & irq_en_d);
    bus_err_d = err_flag;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
      bus_err_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      bus_err_q <= bus_err_d;
    end
  end

  // ****************************************
  // Read mux and acknowledge
  // ****************************************
  always_comb begin
    // Ack follows one cycle after the request and drops the cycle after
    ack_d = wb_req && !ack_q;
    dat_d = dat_q;
    if (ack_d) begin
      dat_d = 32'h0000_0000;
      case (wb_adr_i)
        RIO_OFF_BUS_ERR: begin
          dat_d[RIO_BIT_BUS_ERR] = err_flag;
        end
        RIO_OFF_MASTER_ERR: begin
          dat_d[RIO_BIT_MASTER0] = master_flags[0];
          dat_d[RIO_BIT_MASTER1] = master_flags[1];
        end
        RIO_OFF_FAIL_INFO: begin
          // Bit 16 tells software that the word is frozen
          dat_d[15:0] = fail_info;
          dat_d[16] = fail_held;
        end
        RIO_OFF_ALLOC_REQ: begin
          dat_d = req_q;
        end
        RIO_OFF_ALLOC_RES: begin
          dat_d = res_q;
        end
        RIO_OFF_IRQ_STATUS: begin
          dat_d[RIO_IRQ_W-1:0] = irq_stat_q;
        end
        RIO_OFF_IRQ_ENABLE: begin
          dat_d[RIO_IRQ_W-1:0] = irq_en_q;
        end
        RIO_OFF_REFRESH, RIO_OFF_IRQ_CLEAR: begin
          // Write-only registers read as zero so polling never sees a pulse
          dat_d = 32'h0000_0000;
        end
        default: begin
          // Unmapped offsets are acked and read as zero
          dat_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every pin comes straight from a flop, so no decode glitch
  // can reach the bus or the interrupt line
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq_o = irq_q;
  assign bus_err_o = bus_err_q;

endmodule

// File: dv/rio_top_asserts.sv
module rio_top_asserts
  import rio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic bus_err_i,
  input wire logic bus_err_o
);
  // ****
  // Handshake
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(logic [7:0] a);
    wb_ack_o && $past(!wb_we_i && wb_adr_i == a);
  endsequence
  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_hold;
    !wb_ack_o |-> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved between acks");
  // ****
  // Status
  // ****
  property p_err_set;
    bus_err_i |-> ##2 bus_err_o;
  endproperty
  a_err_set: assert property (p_err_set) else $error("bus error flag not set");
  // Only a register write may clear the sticky flag
  property p_err_hold;
    $fell(bus_err_o) |-> $past(wb_cyc_i && wb_we_i, 2);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("bus error flag lost");
  property p_wo_read;
    s_rd(RIO_OFF_REFRESH) or s_rd(RIO_OFF_IRQ_CLEAR) |-> wb_dat_o == 32'h0;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only reads not zero");
  property p_alloc_range;
    s_rd(RIO_OFF_ALLOC_RES) ##0 wb_dat_o[16] |->
      wb_dat_o[13:0] inside {[14'd3000:14'd3049], [14'd3100:14'd3131]};
  endproperty
  a_alloc_range: assert property (p_alloc_range) else $error("word outside areas");
  property p_info_idle;
    s_rd(RIO_OFF_FAIL_INFO) ##0 !wb_dat_o[16] |-> wb_dat_o[15:0] == 16'h0;
  endproperty
  a_info_idle: assert property (p_info_idle) else $error("unheld failure word");
endmodule

bind rio_top rio_top_asserts rio_top_asserts_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .bus_err_i(bus_err_i), .bus_err_o(bus_err_o)
);

// File: dv/rio_slave_model.sv
module rio_slave_model (
  input wire logic clk_i,
  output logic bus_err_o = 1'b0,
  output logic err_master_o = 1'b0,
  output logic fail_o = 1'b0,
  output logic fail_optic_o = 1'b0,
  output logic [4:0] fail_unit_o = 5'h0,
  output logic fail_high_o = 1'b0,
  output logic fail_master_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Slaves stay silent until asked, as if powered before the controller
  task automatic err(input logic m);
    @(posedge clk_i);
    bus_err_o <= 1'b1;
    err_master_o <= m;
    @(posedge clk_i);
    bus_err_o <= 1'b0;
    err_master_o <= ~m;
  endtask
  // Units of the two masters share one word range
  task automatic fail(input logic o, input logic [4:0] u, input logic h, m);
    @(posedge clk_i);
    fail_o <= 1'b1;
    fail_optic_o <= o;
    fail_unit_o <= u;
    fail_high_o <= h;
    fail_master_o <= m;
    @(posedge clk_i);
    fail_o <= 1'b0;
    fail_optic_o <= ~o;
    fail_unit_o <= ~u;
    fail_high_o <= ~h;
    fail_master_o <= ~m;
  endtask
endmodule

// File: dv/testbench.sv
module testbench
  import rio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic berr, emas, fl, fopt, fhi, fmas, berr_o, irq;
  logic [4:0] funit;
  logic [31:0] q, e;
  logic [7:0] offs[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                           8'h1c, 8'h20, 8'h40};
  int failures = 0;
  int n_tests = 0;
  int k, u, i;
  always #50 clk_i = ~clk_i;
  rio_top rio_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .bus_err_i(berr), .err_master_i(emas), .fail_i(fl), .fail_optic_i(fopt),
    .fail_unit_i(funit), .fail_high_i(fhi), .fail_master_i(fmas),
    .bus_err_o(berr_o), .irq_o(irq)
  );
  rio_slave_model rio_slave_model_inst (
    .clk_i(clk_i), .bus_err_o(berr), .err_master_o(emas), .fail_o(fl),
    .fail_optic_o(fopt), .fail_unit_o(funit), .fail_high_o(fhi), .fail_master_o(fmas)
  );
  // ****
  // Tasks
  // ****
  task automatic finish_test;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, sn);
    n_tests++;
    if (sn !== ex) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
    q = rdat;
    if (n >= 50) chk("ack", 1, 0);
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk_irq(input logic ex);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, ex}, {31'h0, irq});
  endtask
  // Reference word allocation; invalid requests only report the valid bit
  function automatic logic [31:0] exp_alloc(int k, u, i);
    int a;
    bit v;
    a = 3000 + 10 * u + i;
    v = (k == 0) ? (u <= 4 && i < 10) : (u <= 3 && i < 20);
    if (k >= 2) a = 3100 + u + i;
    if (k == 2) v = u <= 31 && i == 0;
    if (k == 3) v = i < 2 && a <= 3131;
    return v ? (32'h10000 | a) : 32'h0;
  endfunction
  initial begin
    #2_000_000;
    failures++;
    finish_test;
  end
  initial begin
    void'($urandom(32'h3e66));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (offs[j]) begin
      bus(0, offs[j], 0);
      e = (offs[j] == RIO_OFF_ALLOC_RES) ? exp_alloc(0, 0, 0) : 32'h0;
      chk("reset", e, q);
    end
    for (int n = 0; n < 48; n++) begin
      k = n % 4;
      u = (n < 16) ? n / 4 + 2 : $urandom % 32;
      i = (n < 16) ? n % 3 : $urandom % 21;
      bus(1, RIO_OFF_ALLOC_REQ, {11'h0, i[4:0], 3'h0, u[4:0], 6'h0, k[1:0]});
      @(posedge clk_i);
      bus(0, RIO_OFF_ALLOC_RES, 0);
      e = exp_alloc(k, u, i);
      chk("alloc", e, q & (e[16] ? 32'h13fff : 32'h10000));
    end
    bus(1, RIO_OFF_IRQ_ENABLE, 32'h3);
    rio_slave_model_inst.err(1'b1);
    bus(0, RIO_OFF_MASTER_ERR, 0);
    chk("master_err", 32'h2, q);
    bus(0, RIO_OFF_BUS_ERR, 0);
    chk("bus_err", 32'h20, q);
    chk("bus_err_o", 32'h1, {31'h0, berr_o});
    chk_irq(1);
    rio_slave_model_inst.err(1'b0);
    bus(0, RIO_OFF_MASTER_ERR, 0);
    chk("master_err", 32'h3, q);
    bus(1, RIO_OFF_REFRESH, 32'h2);
    bus(0, RIO_OFF_BUS_ERR, 0);
    chk("bus_err", 0, q);
    chk("bus_err_o", 0, {31'h0, berr_o});
    rio_slave_model_inst.fail(0, 5'd3, 0, 1);
    bus(0, RIO_OFF_FAIL_INFO, 0);
    chk("rack", 32'h1b130, q & 32'h1ff70);
    rio_slave_model_inst.fail(1, 5'h1a, 1, 0);
    bus(0, RIO_OFF_FAIL_INFO, 0);
    chk("held", 32'h1b130, q & 32'h1ff70);
    bus(1, RIO_OFF_REFRESH, 32'h1);
    bus(0, RIO_OFF_FAIL_INFO, 0);
    chk("optic", 32'h11a10, q & 32'h1ff10);
    bus(1, RIO_OFF_IRQ_ENABLE, 0);
    chk_irq(0);
    bus(0, RIO_OFF_IRQ_STATUS, 0);
    chk("status", 32'h3, q);
    bus(1, RIO_OFF_IRQ_ENABLE, 32'h2);
    chk_irq(1);
    bus(1, RIO_OFF_IRQ_CLEAR, 32'h3);
    chk_irq(0);
    bus(0, RIO_OFF_IRQ_STATUS, 0);
    chk("status", 0, q);
    finish_test;
  end
endmodule
